// ### design/suse_defs.svh
`ifndef SUSE_DEFS_SVH
`define SUSE_DEFS_SVH

// Opcode patterns, 16-bit forms (first halfword)
`define SUSE_OP16_STH_REG   7'h29
`define SUSE_OP16_SUB_THREE_BIT_IMMEDIATE  7'h0f
`define SUSE_OP16_SUB_BYTE_IMMEDIATE  5'h07
// Opcode patterns, 32-bit forms (first halfword upper bits)
`define SUSE_OP32_STH       12'hf82
`define SUSE_OP32_STW       12'hf84
`define SUSE_OP32_SUB_MOD   5'h1e
`define SUSE_OP32_SUB_W     5'h1e
// Second-halfword selectors
`define SUSE_USER_SEL       4'he
`define SUSE_REGOFF_SEL     6'h00
// Special register numbers
`define SUSE_REG_SP         4'hd
`define SUSE_REG_PC         4'hf
// Access sizes in bytes
`define SUSE_SIZE_HALF      3'h2
`define SUSE_SIZE_WORD      3'h4
// Byte enables
`define SUSE_BE_HALF        4'h3
`define SUSE_BE_WORD        4'hf

`endif

// ### design/suse_pkg.sv
package suse_pkg;

  // Memory store request toward the memory system
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  byte_en;
    logic [2:0]  size;
    logic        unpriv;
  } suse_store_t;

  // Register write-back
  typedef struct packed {
    logic [3:0]  rd;
    logic [31:0] value;
  } suse_wb_t;

  // Condition flags word
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } suse_flags_t;

  // Decoded operation class
  typedef enum logic [6:0] {
    SUSE_OP_NONE   = 7'h01,
    SUSE_OP_STH    = 7'h02,
    SUSE_OP_STHU   = 7'h04,
    SUSE_OP_STWU   = 7'h08,
    SUSE_OP_SUB    = 7'h10,
    SUSE_OP_REDIR  = 7'h20,
    SUSE_OP_UNDEF  = 7'h40
  } suse_op_t;

endpackage

// ### design/suse_adder.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************
// Add with carry for the subtract path
// ************************************
module suse_adder
(
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  wire logic        carry_in,
  output logic      [31:0] result,
  output logic             carry_out,
  output logic             overflow
);

  logic [32:0] sum;

  // Unsigned sum with carry, signed overflow from operand signs
  always_comb
  begin
    sum       = {1'b0, op_a} + {1'b0, op_b} + {32'h0, carry_in};
    result    = sum[31:0];
    carry_out = sum[32];
    overflow  = (op_a[31] == op_b[31]) && (sum[31] != op_a[31]);
  end

endmodule

`default_nettype wire

// ### design/suse_exec.sv
// Overview of operation
// RULE_01: Halfword register store: base plus shifted offset
// RULE_02: Halfword stores write low sixteen bits only
// RULE_03: User halfword store: base plus byte immediate
// RULE_04: User stores carry unprivileged attribute
// RULE_05: Base 1111 undefined; source 13/15 flagged
// RULE_06: User store offset additive, zero to 255
// RULE_07: User stores never write back base
// RULE_08: User word store writes full word
// RULE_09: User stores selected by bits 11:8 1110
// RULE_10: Three-bit subtract sets flags outside block
// RULE_11: Eight-bit subtract shares source and destination
// RULE_12: Modified subtract: expanded immediate, S flags
// RULE_13: Redirect to compare or stack variant
// RULE_14: Modified subtract unpredictable register cases
// RULE_15: Wide subtract: zero-extend, no flags, redirects
// RULE_16: Subtract as add of inverse plus one
// RULE_17: Flags from result, carry and overflow
// RULE_18: Wide register store: 2-bit shift, checks
// RULE_19: Narrow register store uses zero shift
// RULE_20: Failed condition suppresses every effect
`timescale 1ns/100ps
`default_nettype none
`include "suse_defs.svh"

module suse_exec
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 instr_valid,
  input  wire logic [31:0]          instr,
  input  wire logic                 instr_is32,
  input  wire logic                 cond_pass,
  input  wire logic                 in_cond_exec_block,
  input  wire logic [31:0]          base_value,
  input  wire logic [31:0]          offset_value,
  input  wire logic [31:0]          source_value,
  input  wire logic [31:0]          expanded_imm,
  input  wire suse_pkg::suse_flags_t flags_in,
  output logic                      store_valid,
  output suse_pkg::suse_store_t     store_req,
  output logic                      wb_valid,
  output suse_pkg::suse_wb_t        wb,
  output logic                      flags_valid,
  output suse_pkg::suse_flags_t     flags_out,
  output logic                      undef_pulse,
  output logic                      unpred_pulse,
  output logic                      redirect_pulse,
  output logic [1:0]                redirect_kind
);

  import suse_pkg::*;

  // ************************************
  // Instruction fields
  // ************************************
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic [3:0]  base_reg_field;
  logic [3:0]  source_reg_field;
  logic [3:0]  offset_reg_field;
  logic [3:0]  dest_field;
  logic [7:0]  byte_immediate;
  logic [2:0]  three_bit_immediate;
  logic [11:0] twelve_bit_immediate;
  logic        s_bit;

  // Split halfwords; hw1 is the first fetched halfword
  always_comb
  begin
    hw1                  = instr[31:16];
    hw2                  = instr[15:0];
    base_reg_field       = hw1[3:0];
    source_reg_field     = hw2[15:12];
    offset_reg_field     = hw2[3:0];
    dest_field           = hw2[11:8];
    byte_immediate       = hw2[7:0];
    three_bit_immediate  = hw2[14:12];
    twelve_bit_immediate = {hw1[10], hw2[14:12], hw2[7:0]};
    s_bit                = hw1[4];
  end

  // ************************************
  // Decode
  // ************************************
  suse_op_t    op;
  logic [31:0] addr_c;
  logic [31:0] sub_imm;
  logic [3:0]  sub_rd;
  logic        sub_setflags;
  logic        unpred_c;
  logic [1:0]  redir_c;
  logic [15:0] nhw;

  // Classify and form operands for one instruction
  always_comb
  begin
    op           = SUSE_OP_NONE;
    addr_c       = 32'h0;
    sub_imm      = 32'h0;
    sub_rd       = 4'h0;
    sub_setflags = 1'b0;
    unpred_c     = 1'b0;
    redir_c      = 2'h0;
    nhw          = instr[15:0];
    if (!instr_is32)
    begin
      if (nhw[15:9] == `SUSE_OP16_STH_REG)
      begin
        op     = SUSE_OP_STH;
        addr_c = base_value + offset_value; // RULE_19 RULE_01
      end
      else if (nhw[15:9] == `SUSE_OP16_SUB_THREE_BIT_IMMEDIATE)
      begin
        op           = SUSE_OP_SUB;
        sub_imm      = {29'h0, nhw[8:6]}; // RULE_10
        sub_rd       = {1'b0, nhw[2:0]};
        sub_setflags = !in_cond_exec_block; // RULE_10
      end
      else if (nhw[15:11] == `SUSE_OP16_SUB_BYTE_IMMEDIATE)
      begin
        op           = SUSE_OP_SUB;
        sub_imm      = {24'h0, nhw[7:0]}; // RULE_11
        sub_rd       = {1'b0, nhw[10:8]}; // RULE_11
        sub_setflags = !in_cond_exec_block;
      end
    end
    else if (hw1[15:4] == `SUSE_OP32_STH || hw1[15:4] == `SUSE_OP32_STW)
    begin
      if (hw2[11:8] == `SUSE_USER_SEL) // RULE_09
      begin
        op     = (hw1[15:4] == `SUSE_OP32_STH) ? SUSE_OP_STHU : SUSE_OP_STWU;
        addr_c = base_value + {24'h0, byte_immediate}; // RULE_03 RULE_06 RULE_07 RULE_08
        if (base_reg_field == `SUSE_REG_PC)
          op = SUSE_OP_UNDEF; // RULE_05
        unpred_c = (source_reg_field == `SUSE_REG_SP) ||
                   (source_reg_field == `SUSE_REG_PC); // RULE_05
      end
      else if (hw1[15:4] == `SUSE_OP32_STH && hw2[11:6] == `SUSE_REGOFF_SEL)
      begin
        op     = SUSE_OP_STH;
        addr_c = base_value + (offset_value << hw2[5:4]); // RULE_18 RULE_01
        if (base_reg_field == `SUSE_REG_PC)
          op = SUSE_OP_UNDEF; // RULE_18
        unpred_c = (source_reg_field == `SUSE_REG_SP) ||
                   (source_reg_field == `SUSE_REG_PC) ||
                   (offset_reg_field == `SUSE_REG_SP) ||
                   (offset_reg_field == `SUSE_REG_PC); // RULE_18
      end
    end
    else if (hw1[15:11] == `SUSE_OP32_SUB_MOD && hw1[9:5] == 5'h0d && !hw2[15])
    begin
      op           = SUSE_OP_SUB;
      sub_imm      = expanded_imm; // RULE_12
      sub_rd       = dest_field;
      sub_setflags = s_bit; // RULE_12
      if (dest_field == `SUSE_REG_PC && s_bit)
      begin
        op      = SUSE_OP_REDIR;
        redir_c = 2'h1; // RULE_13
      end
      else if (base_reg_field == `SUSE_REG_SP)
      begin
        op      = SUSE_OP_REDIR;
        redir_c = 2'h2; // RULE_13
      end
      unpred_c = (dest_field == `SUSE_REG_SP) ||
                 (dest_field == `SUSE_REG_PC && !s_bit) ||
                 (base_reg_field == `SUSE_REG_PC); // RULE_14
    end
    else if (hw1[15:11] == `SUSE_OP32_SUB_W && hw1[9:4] == 6'h2a && !hw2[15])
    begin
      op           = SUSE_OP_SUB;
      sub_imm      = {20'h0, twelve_bit_immediate}; // RULE_15
      sub_rd       = dest_field;
      sub_setflags = 1'b0; // RULE_15
      if (base_reg_field == `SUSE_REG_PC)
      begin
        op      = SUSE_OP_REDIR;
        redir_c = 2'h3; // RULE_15
      end
      else if (base_reg_field == `SUSE_REG_SP)
      begin
        op      = SUSE_OP_REDIR;
        redir_c = 2'h2;
      end
      unpred_c = (dest_field == `SUSE_REG_SP) || (dest_field == `SUSE_REG_PC); // RULE_15
    end
  end

  // ************************************
  // Subtract datapath
  // ************************************
  logic [31:0] diff;
  logic        diff_c;
  logic        diff_v;

  // Source plus inverted immediate plus one
  suse_adder u_adder
  (
    .op_a      (base_value),
    .op_b      (~sub_imm),
    .carry_in  (1'b1),
    .result    (diff),
    .carry_out (diff_c),
    .overflow  (diff_v)
  ); // RULE_16

  // ************************************
  // Output registers
  // ************************************
  logic        store_valid_reg, store_valid_next;
  suse_store_t store_reg, store_next;
  logic        wb_valid_reg, wb_valid_next;
  suse_wb_t    wb_reg, wb_next;
  logic        flags_valid_reg, flags_valid_next;
  suse_flags_t flags_reg, flags_next;
  logic        undef_reg, undef_next;
  logic        unpred_reg, unpred_next;
  logic        redir_reg, redir_next;
  logic [1:0]  redir_kind_reg, redir_kind_next;
  logic        go;

  // Next outputs; nothing happens unless the condition passes
  always_comb
  begin
    go               = instr_valid && cond_pass; // RULE_20
    store_valid_next = 1'b0;
    store_next       = store_reg;
    wb_valid_next    = 1'b0;
    wb_next          = wb_reg;
    flags_valid_next = 1'b0;
    flags_next       = flags_reg;
    undef_next       = 1'b0;
    unpred_next      = 1'b0;
    redir_next       = 1'b0;
    redir_kind_next  = redir_kind_reg;
    if (go)
    begin
      unpred_next = unpred_c;
      case (op)
        SUSE_OP_STH, SUSE_OP_STHU:
        begin
          store_valid_next   = 1'b1;
          store_next.addr    = addr_c;
          store_next.data    = {16'h0, source_value[15:0]}; // RULE_02
          store_next.byte_en = `SUSE_BE_HALF; // RULE_02
          store_next.size    = `SUSE_SIZE_HALF;
          store_next.unpriv  = (op == SUSE_OP_STHU); // RULE_04
        end
        SUSE_OP_STWU:
        begin
          store_valid_next   = 1'b1;
          store_next.addr    = addr_c;
          store_next.data    = source_value; // RULE_08
          store_next.byte_en = `SUSE_BE_WORD;
          store_next.size    = `SUSE_SIZE_WORD;
          store_next.unpriv  = 1'b1; // RULE_04
        end
        SUSE_OP_SUB:
        begin
          wb_valid_next = 1'b1;
          wb_next.rd    = sub_rd;
          wb_next.value = diff; // RULE_16
          if (sub_setflags)
          begin
            flags_valid_next = 1'b1;
            flags_next.n     = diff[31]; // RULE_17
            flags_next.z     = (diff == 32'h0);
            flags_next.c     = diff_c;
            flags_next.v     = diff_v;
          end
        end
        SUSE_OP_REDIR:
        begin
          redir_next      = 1'b1; // RULE_13
          redir_kind_next = redir_c;
          unpred_next     = 1'b0;
        end
        SUSE_OP_UNDEF:
        begin
          undef_next  = 1'b1; // RULE_05
          unpred_next = 1'b0;
        end
        default:
        begin
          unpred_next = 1'b0;
        end
      endcase
    end
    // Flags follow flags_in when not written
    if (!flags_valid_next)
      flags_next = flags_in;
  end

  // Register all outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      store_valid_reg <= 1'b0;
      store_reg       <= '0;
      wb_valid_reg    <= 1'b0;
      wb_reg          <= '0;
      flags_valid_reg <= 1'b0;
      flags_reg       <= '0;
      undef_reg       <= 1'b0;
      unpred_reg      <= 1'b0;
      redir_reg       <= 1'b0;
      redir_kind_reg  <= 2'h0;
    end
    else
    begin
      store_valid_reg <= store_valid_next;
      store_reg       <= store_next;
      wb_valid_reg    <= wb_valid_next;
      wb_reg          <= wb_next;
      flags_valid_reg <= flags_valid_next;
      flags_reg       <= flags_next;
      undef_reg       <= undef_next;
      unpred_reg      <= unpred_next;
      redir_reg       <= redir_next;
      redir_kind_reg  <= redir_kind_next;
    end
  end

  // Drive ports straight from flip-flops
  assign store_valid    = store_valid_reg;
  assign store_req      = store_reg;
  assign wb_valid       = wb_valid_reg;
  assign wb             = wb_reg;
  assign flags_valid    = flags_valid_reg;
  assign flags_out      = flags_reg;
  assign undef_pulse    = undef_reg;
  assign unpred_pulse   = unpred_reg;
  assign redirect_pulse = redir_reg;
  assign redirect_kind  = redir_kind_reg;

  // ************************************
  // Checks
  // ************************************
  a_no_effect_fail: assert property (@(posedge clk) disable iff (!arst_n)
    (instr_valid && !cond_pass) |=> !store_valid && !wb_valid && !flags_valid) // RULE_20
    else $error("effect despite failed condition");
  a_half_two_bytes: assert property (@(posedge clk) disable iff (!arst_n)
    (store_valid && store_req.size == 3'h2) |-> store_req.byte_en == 4'h3 &&
    store_req.data[31:16] == 16'h0) // RULE_02
    else $error("halfword store not two bytes");
  a_user_unpriv: assert property (@(posedge clk) disable iff (!arst_n)
    (instr_valid && cond_pass && instr_is32 && instr[11:8] == 4'he &&
     instr[31:20] == 12'hf84 && instr[19:16] != 4'hf) |=>
    store_valid && store_req.unpriv && store_req.size == 3'h4) // RULE_04
    else $error("user word store lacks unprivileged attribute");
  a_user_addr: assert property (@(posedge clk) disable iff (!arst_n)
    (instr_valid && cond_pass && instr_is32 && instr[11:8] == 4'he &&
     instr[31:20] == 12'hf82 && instr[19:16] != 4'hf) |=>
    store_req.addr == $past(base_value) + {24'h0, $past(instr[7:0])}) // RULE_03
    else $error("user halfword address wrong");
  a_base_undef: assert property (@(posedge clk) disable iff (!arst_n)
    (instr_valid && cond_pass && instr_is32 && instr[11:8] == 4'he &&
     instr[31:20] == 12'hf84 && instr[19:16] == 4'hf) |=> undef_pulse && !store_valid) // RULE_05
    else $error("base 1111 not undefined");
  a_sub_value: assert property (@(posedge clk) disable iff (!arst_n)
    (go && op == SUSE_OP_SUB) |=> wb_valid && wb.value == $past(base_value) - $past(sub_imm)) // RULE_16
    else $error("subtract result wrong");
  a_flag_zero: assert property (@(posedge clk) disable iff (!arst_n)
    flags_valid |-> flags_out.z == (wb.value == 32'h0) && flags_out.n == wb.value[31]) // RULE_17
    else $error("flags disagree with result");
  a_it_no_flags: assert property (@(posedge clk) disable iff (!arst_n)
    (instr_valid && !instr_is32 && in_cond_exec_block) |=> !flags_valid) // RULE_10
    else $error("flags changed inside conditional block");
  a_wide_no_flags: assert property (@(posedge clk) disable iff (!arst_n)
    (instr_valid && instr_is32 && instr[31:27] == 5'h1e && instr[25:20] == 6'h2a) |=>
    !flags_valid) // RULE_15
    else $error("wide subtract changed flags");

endmodule

`default_nettype wire

// ### testbench/suse_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// *********************************
// Memory system and protection unit
// *********************************
module suse_mem_model
#(
  parameter logic [31:0] PRIV_BASE = 32'h0000_8000
)
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  store_valid,
  input  wire suse_pkg::suse_store_t store_req,
  output logic [7:0]                 n_user_faults,
  output logic [31:0]                last_word
);
  import suse_pkg::*;

  // Takes each store; user-level writes at or above the boundary are refused
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      n_user_faults <= 8'h00;
      last_word     <= 32'h0000_0000;
    end
    else if (store_valid)
    begin
      if (store_req.unpriv && store_req.addr >= PRIV_BASE)
        n_user_faults <= n_user_faults + 8'h01;
      else
        for (int b = 0; b < 4; b++)
          if (store_req.byte_en[b])
            last_word[8*b +: 8] <= store_req.data[8*b +: 8];
    end
  end
endmodule

`default_nettype wire

// ### testbench/test_suse_exec.sv
`timescale 1ns/100ps
`default_nettype none

module test_suse_exec;
  import suse_pkg::*;

  logic        clk;
  logic        arst_n;
  logic        instr_valid;
  logic [31:0] instr;
  logic        instr_is32;
  logic        cond_pass;
  logic        in_cond_exec_block;
  logic [31:0] base_value;
  logic [31:0] offset_value;
  logic [31:0] source_value;
  logic [31:0] expanded_imm;
  suse_flags_t flags_in;
  logic        store_valid;
  suse_store_t store_req;
  logic        wb_valid;
  suse_wb_t    wb;
  logic        flags_valid;
  suse_flags_t flags_out;
  logic        undef_pulse;
  logic        unpred_pulse;
  logic        redirect_pulse;
  logic [1:0]  redirect_kind;
  logic [7:0]  n_user_faults;
  logic [31:0] last_word;
  int          err_total;
  int          n_compared;

  // ****************
  // Design and model
  // ****************
  suse_exec u_suse_exec (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_is32(instr_is32), .cond_pass(cond_pass), .in_cond_exec_block(in_cond_exec_block),
    .base_value(base_value), .offset_value(offset_value), .source_value(source_value),
    .expanded_imm(expanded_imm), .flags_in(flags_in), .store_valid(store_valid),
    .store_req(store_req), .wb_valid(wb_valid), .wb(wb), .flags_valid(flags_valid),
    .flags_out(flags_out), .undef_pulse(undef_pulse), .unpred_pulse(unpred_pulse),
    .redirect_pulse(redirect_pulse), .redirect_kind(redirect_kind));

  suse_mem_model u_suse_mem_model (.clk(clk), .arst_n(arst_n), .store_valid(store_valid),
    .store_req(store_req), .n_user_faults(n_user_faults), .last_word(last_word));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // *******
  // Helpers
  // *******
  task automatic report_and_stop;
    $display("TB: compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Presents one instruction; returns one edge later when its answer stands
  task automatic exec(input logic [31:0] ins, input logic w, input logic cp, input logic blk,
                      input logic [31:0] b, input logic [31:0] s, input logic [31:0] e);
    instr_valid = 1'b1;
    instr = ins;
    instr_is32 = w;
    cond_pass = cp;
    in_cond_exec_block = blk;
    base_value = b;
    source_value = s;
    offset_value = e;
    expanded_imm = e;
    @(posedge clk);
    #1;
  endtask

  task automatic idle;
    instr_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Reference subtract: {n,z,c,v,result}
  function automatic logic [35:0] sub_ref(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] sum;
    sum = {1'b0, a} + {1'b0, ~b} + 33'h1;
    sub_ref = {sum[31], sum[31:0] == 32'h0, sum[32], (a[31] != b[31]) && (sum[31] != a[31]),
               sum[31:0]};
  endfunction

  task automatic chk_sub(input logic [3:0] rd, input logic [31:0] a, input logic [31:0] b,
                         input logic fv);
    logic [35:0] r;
    r = sub_ref(a, b);
    chk("wb_valid", wb_valid, 1'b1);
    chk("wb_rd", wb.rd, rd);
    chk("wb_value", wb.value, r[31:0]);
    chk("flags_valid", flags_valid, fv);
    if (fv)
      chk("flags_out", flags_out, r[35:32]);
  endtask

  task automatic chk_store(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                           input logic [2:0] sz, input logic up);
    chk("store_valid", store_valid, 1'b1);
    chk("store_addr", store_req.addr, a);
    chk("store_data", store_req.data, d);
    chk("store_be", store_req.byte_en, be);
    chk("store_size", store_req.size, sz);
    chk("store_unpriv", store_req.unpriv, up);
    chk("no_writeback", wb_valid, 1'b0);
  endtask

  // Runs an encoding and compares the three event pulses
  task automatic chk_ev(input logic [31:0] ins, input logic un, input logic ud, input logic rp,
                        input logic [1:0] rk);
    exec(ins, 1'b1, 1'b1, 1'b0, 32'h10, 32'h5, 32'h1);
    chk("unpred", unpred_pulse, un);
    chk("undef", undef_pulse, ud);
    chk("redirect", redirect_pulse, rp);
    if (rp)
      chk("redirect_kind", redirect_kind, rk);
  endtask

  function automatic logic [31:0] t3(input logic [3:0] rn, input logic [3:0] rd, input logic s);
    t3 = {5'h1e, 1'b0, 5'h0d, s, rn, 4'h0, rd, 8'h00};
  endfunction

  function automatic logic [31:0] t4(input logic [3:0] rn, input logic [3:0] rd,
                                     input logic [11:0] im);
    t4 = {5'h1e, im[11], 6'h2a, rn, 1'b0, im[10:8], rd, im[7:0]};
  endfunction

  function automatic logic [31:0] ust(input logic w, input logic [3:0] rn, input logic [3:0] rt,
                                      input logic [7:0] im);
    ust = {(w ? 12'hf84 : 12'hf82), rn, rt, 4'he, im};
  endfunction

  function automatic logic [31:0] srh(input logic [3:0] rn, input logic [3:0] rt,
                                      input logic [1:0] sh, input logic [3:0] rm);
    srh = {12'hf82, rn, rt, 6'h00, sh, rm};
  endfunction

  // Watchdog
  initial
  begin
    #100000;
    err_total++;
    report_and_stop();
  end

  // *****
  // Tests
  // *****
  initial
  begin
    err_total = 0;
    n_compared = 0;
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 32'h0;
    instr_is32 = 1'b0;
    cond_pass = 1'b1;
    in_cond_exec_block = 1'b0;
    base_value = 32'h0;
    offset_value = 32'h0;
    source_value = 32'h0;
    expanded_imm = 32'h0;
    flags_in = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("reset_store", store_valid, 1'b0);
    chk("reset_wb", wb_valid, 1'b0);
    // Narrow and wide register-offset halfword stores, back to back
    exec({16'h0, 7'h29, 3'd2, 3'd1, 3'd0}, 1'b0, 1'b1, 1'b0, 32'h1000, 32'habcd1234, 32'h22);
    chk_store(32'h1022, 32'h1234, 4'h3, 3'h2, 1'b0);
    for (int sh = 0; sh < 4; sh++)
    begin
      exec(srh(4'h3, 4'h1, sh[1:0], 4'h2), 1'b1, 1'b1, 1'b0, 32'h2000, 32'h5a5a, 32'h11);
      chk_store(32'h2000 + (32'h11 << sh), 32'h5a5a, 4'h3, 3'h2, 1'b0);
    end
    chk_ev(srh(4'h3, 4'h1, 2'h0, 4'hd), 1'b1, 1'b0, 1'b0, 2'h0);
    chk_ev(srh(4'hf, 4'h1, 2'h0, 4'h2), 1'b0, 1'b1, 1'b0, 2'h0);
    // User stores with SP base, offsets at both ends
    for (int k = 0; k < 4; k++)
    begin
      exec(ust(k[0], 4'hd, 4'h2, k[1] ? 8'hff : 8'h00), 1'b1, 1'b1, 1'b0, 32'h100,
           32'h89abcdef, 32'h0);
      chk_store(32'h100 + (k[1] ? 32'hff : 32'h0), k[0] ? 32'h89abcdef : 32'hcdef,
                k[0] ? 4'hf : 4'h3, k[0] ? 3'h4 : 3'h2, 1'b1);
    end
    idle();
    chk("mem_word", last_word, 32'h89abcdef);
    exec(ust(1'b1, 4'h1, 4'h2, 8'h04), 1'b1, 1'b1, 1'b0, 32'h8000, 32'h1, 32'h0);
    idle();
    chk("user_fault", n_user_faults, 8'h01);
    chk_ev(ust(1'b1, 4'hf, 4'h2, 8'h00), 1'b0, 1'b1, 1'b0, 2'h0);
    chk("undef_no_store", store_valid, 1'b0);
    chk_ev(ust(1'b0, 4'h1, 4'hd, 8'h00), 1'b1, 1'b0, 1'b0, 2'h0);
    chk_ev(ust(1'b1, 4'h1, 4'hf, 8'h00), 1'b1, 1'b0, 1'b0, 2'h0);
    // Failed condition: nothing happens
    exec(ust(1'b1, 4'h1, 4'h2, 8'h00), 1'b1, 1'b0, 1'b0, 32'h100, 32'h1, 32'h0);
    chk("cond_store", store_valid, 1'b0);
    exec({16'h0, 7'h0f, 3'd7, 3'd1, 3'd2}, 1'b0, 1'b0, 1'b0, 32'h7, 32'h0, 32'h0);
    chk("cond_wb", wb_valid, 1'b0);
    chk("cond_flags", flags_valid, 1'b0);
    // Narrow subtracts, in and out of a conditional block
    exec({16'h0, 7'h0f, 3'd7, 3'd1, 3'd2}, 1'b0, 1'b1, 1'b0, 32'h7, 32'h0, 32'h0);
    chk_sub(4'h2, 32'h7, 32'h7, 1'b1);
    flags_in = 4'h9;
    exec({16'h0, 7'h0f, 3'd7, 3'd1, 3'd2}, 1'b0, 1'b1, 1'b1, 32'h7, 32'h0, 32'h0);
    chk_sub(4'h2, 32'h7, 32'h7, 1'b0);
    chk("flags_hold", flags_out, 32'h9);
    exec({16'h0, 5'h07, 3'd5, 8'hff}, 1'b0, 1'b1, 1'b0, 32'h10, 32'h0, 32'h0);
    chk_sub(4'h5, 32'h10, 32'hff, 1'b1);
    // Flag-optional wide subtract and its redirects
    for (int s = 0; s < 2; s++)
    begin
      exec(t3(4'h2, 4'h3, s[0]), 1'b1, 1'b1, 1'b0, 32'h7fffffff, 32'h0, 32'h80000000);
      chk_sub(4'h3, 32'h7fffffff, 32'h80000000, s[0]);
    end
    chk_ev(t3(4'h2, 4'hf, 1'b1), 1'b0, 1'b0, 1'b1, 2'h1);
    chk_ev(t3(4'hd, 4'h3, 1'b0), 1'b0, 1'b0, 1'b1, 2'h2);
    chk_ev(t3(4'h2, 4'hd, 1'b1), 1'b1, 1'b0, 1'b0, 2'h0);
    chk_ev(t3(4'h2, 4'hf, 1'b0), 1'b1, 1'b0, 1'b0, 2'h0);
    chk_ev(t3(4'hf, 4'h3, 1'b1), 1'b1, 1'b0, 1'b0, 2'h0);
    // Twelve-bit subtract
    exec(t4(4'h2, 4'h4, 12'hfff), 1'b1, 1'b1, 1'b0, 32'h1000, 32'h0, 32'h0);
    chk_sub(4'h4, 32'h1000, 32'hfff, 1'b0);
    chk_ev(t4(4'hf, 4'h4, 12'h001), 1'b0, 1'b0, 1'b1, 2'h3);
    chk_ev(t4(4'h2, 4'hd, 12'h001), 1'b1, 1'b0, 1'b0, 2'h0);
    chk_ev(t4(4'h2, 4'hf, 12'h001), 1'b1, 1'b0, 1'b0, 2'h0);
    chk_ev(t4(4'hd, 4'h4, 12'h001), 1'b0, 1'b0, 1'b1, 2'h2);
    idle();
    report_and_stop();
  end
endmodule

`default_nettype wire
